// file: src/rffc_frame_config.sv
// Frame format configuration registers with APB access and frame-boundary latched framing outputs.
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/10ps
// Overview of operation
// R1: Speed codes 0 to 3 select fc/128, fc/64, fc/32, fc/16; others unused.
// R2: An unsupported speed code disables transmit and receive.
// R3: Parity suppression sends FIFO bits without type A parity; host uses no-CRC transmit.
// R4: Raw receive stores parity bits and skips parity and CRC checks at 106 only.
// R5: Host uses both parity options only in reader modes, never card emulation.
// R6: Transport framing prepends F0 and length on transmit, drops F0 on receive.
// R7: Host keeps transport framing off in bit rate detection mode.
// R8: Pulse width code in bits 4 to 1 sets type A pause width in carrier periods.
// R9: At fc/128 codes give 42 down to 33 periods; faster speeds are shorter.
// R10: Sub-carrier stream with period zero gives 128, 120, 112 periods.
// R11: Host sets anticollision bit only for type A bit-oriented reader frames.
// R12: Extra guard time field inserts 0 to 7 etu between type B characters.
// R13: Start-of-frame low part is 10 or 11 etu.
// R14: Start-of-frame high part is 2 or 3 etu.
// R15: End-of-frame low part is 10 or 11 etu.
// R16: Mid-spec bit overrides SOF and EOF lengths with mid values, 2.5 etu high.
// R17: Skip card SOF accepts type B responses without start-of-frame.
// R18: Skip card EOF accepts type B responses without end-of-frame.
// R19: Preamble select gives 48, 64, 80 or 96 bits.
// R20: Minimum TR1 code 0 default, code 1 64/fs or 32/fs, others unused.
// R21: Separate transmit and receive speed codes select rates independently.
// R22: Changed settings apply only from the next frame start; here a change written in a frame's first two edges still loads into that frame.
module rffc_frame_config
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic frame_idle,
    input wire logic [1:0] stream_tx_period,
    output logic tx_enable,
    output logic rx_enable,
    output logic [3:0] tx_speed_code,
    output logic [3:0] rx_speed_code,
    output logic suppress_tx_parity,
    output logic raw_rx_with_parity,
    output logic transport_frame_enable,
    output logic [7:0] transport_start_byte,
    output logic anticollision_frame,
    output logic [7:0] pause_width,
    output logic [2:0] extra_guard_time,
    output logic [4:0] sof_low_half_etu,
    output logic [4:0] sof_high_half_etu,
    output logic [4:0] eof_low_half_etu,
    output logic skip_card_sof,
    output logic skip_card_eof,
    output logic [6:0] preamble_bits,
    output logic [6:0] min_tr1_fs
);
    import rffc_pkg::*;

    logic [7:0] type_a_frame_settings;
    logic [7:0] type_b_frame_settings;
    logic [7:0] type_b_f_response_settings;
    logic [7:0] speed_settings;
    logic [7:0] mode_settings;
    logic idle_s1;
    logic idle_s2;
    logic access;
    logic mapped;
    logic [31:0] next_prdata;
    logic [3:0] tx_code;
    logic [3:0] rx_code;
    logic [3:0] pw_code;
    logic [7:0] next_pause;
    logic [7:0] pw_base;
    logic [3:0] pw_step;
    logic stream_mode;
    logic [4:0] next_sof_low;
    logic [4:0] next_sof_high;
    logic [4:0] next_eof;

    assign access = psel && penable && clk_en;
    assign tx_code = speed_settings[7:4];
    assign rx_code = speed_settings[3:0];
    assign pw_code = type_a_frame_settings[4:1];
    assign stream_mode = (mode_settings[3:0] == rffc_om_subcarrier) && (stream_tx_period == 2'b00);

    // The frame boundary comes from the coder's clock tree, so it is synchronised before use.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            idle_s1 <= 1'b0;
            idle_s2 <= 1'b0;
        end
        else if (clk_en)
        begin
            idle_s1 <= frame_idle;
            idle_s2 <= idle_s1;
        end
    end

    always_comb
    begin
        mapped = 1'b1;
        next_prdata = 32'h0000_0000;
        unique case (paddr)
            rffc_off_type_a: next_prdata = {24'h0, type_a_frame_settings};
            rffc_off_type_b: next_prdata = {24'h0, type_b_frame_settings};
            rffc_off_resp: next_prdata = {24'h0, type_b_f_response_settings};
            rffc_off_speed: next_prdata = {24'h0, speed_settings};
            rffc_off_mode: next_prdata = {24'h0, mode_settings};
            rffc_off_status: next_prdata = {30'h0, rx_enable, tx_enable};
            default: mapped = 1'b0;
        endcase
    end

    // Zero wait states: pready is registered and rises in the access phase's first edge.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= rffc_status_reset;
        end
        else if (clk_en)
        begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
            prdata <= (psel && !penable && !pwrite) ? next_prdata : 32'h0000_0000;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            type_a_frame_settings <= rffc_type_a_reset;
            type_b_frame_settings <= rffc_type_b_reset;
            type_b_f_response_settings <= rffc_resp_reset;
            speed_settings <= rffc_speed_reset;
            mode_settings <= rffc_mode_reset;
        end
        else if (access && pready && pwrite)
        begin
            if (paddr == rffc_off_type_a)
                type_a_frame_settings <= pwdata[7:0];
            if (paddr == rffc_off_type_b)
                type_b_frame_settings <= {pwdata[7:1], 1'b0};
            if (paddr == rffc_off_resp)
                type_b_f_response_settings <= {pwdata[7:4], 2'b00, pwdata[1:0]};
            if (paddr == rffc_off_speed)
                speed_settings <= pwdata[7:0];
            if (paddr == rffc_off_mode)
                mode_settings <= {4'h0, pwdata[3:0]};
        end
    end

    always_comb
    begin
        unique case (tx_code[1:0]) // [R9]
            2'b00: pw_base = rffc_pw_base_106;
            2'b01: pw_base = rffc_pw_base_212;
            2'b10: pw_base = rffc_pw_base_424;
            default: pw_base = rffc_pw_base_848;
        endcase
        // Codes 0..7 add upward, 15 and 14 wrap below the base by one and two periods.
        pw_step = pw_code;
        next_pause = pw_base + {4'h0, pw_step};
        if (pw_code[3])
            next_pause = pw_base - 8'(5'h10 - {1'b0, pw_code});
        if (stream_mode) // [R10]
        begin
            if (pw_code == 4'hf)
                next_pause = rffc_pw_stream_f;
            else if (pw_code == 4'he)
                next_pause = rffc_pw_stream_e;
            else
                next_pause = rffc_pw_stream_0;
        end
    end

    always_comb
    begin
        next_sof_low = type_b_frame_settings[rffc_bit_sof_low] ? {rffc_sof_low_long, 1'b0} : {rffc_sof_low_short, 1'b0};
        next_sof_high = type_b_frame_settings[rffc_bit_sof_high] ? {rffc_sof_high_long, 1'b0}
                                                                  : {rffc_sof_high_short, 1'b0};
        next_eof = type_b_frame_settings[rffc_bit_eof_low] ? {rffc_eof_long, 1'b0} : {rffc_eof_short, 1'b0};
        if (type_b_frame_settings[rffc_bit_mid_spec]) // [R16]
        begin
            next_sof_low = rffc_mid_sof_low_half;
            next_sof_high = rffc_mid_sof_high_half;
            next_eof = rffc_mid_eof_half;
        end
    end

    // Outputs load only while the synchronised idle is high, two edges behind the coder, so a frame's first two edges can still load a change.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tx_enable <= 1'b0;
            rx_enable <= 1'b0;
            tx_speed_code <= rffc_rate_106;
            rx_speed_code <= rffc_rate_106;
            suppress_tx_parity <= 1'b0;
            raw_rx_with_parity <= 1'b0;
            transport_frame_enable <= 1'b0;
            transport_start_byte <= rffc_start_byte;
            anticollision_frame <= 1'b0;
            pause_width <= rffc_pw_base_106;
            extra_guard_time <= 3'h0;
            sof_low_half_etu <= {rffc_sof_low_short, 1'b0};
            sof_high_half_etu <= {rffc_sof_high_short, 1'b0};
            eof_low_half_etu <= {rffc_eof_short, 1'b0};
            skip_card_sof <= 1'b0;
            skip_card_eof <= 1'b0;
            preamble_bits <= rffc_preamble_base;
            min_tr1_fs <= rffc_tr1_default;
        end
        else if (clk_en && idle_s2) // [R22]
        begin
            tx_speed_code <= tx_code; // [R21]
            rx_speed_code <= rx_code; // [R21]
            tx_enable <= (tx_code <= rffc_rate_848) && (rx_code <= rffc_rate_848); // [R1] [R2]
            rx_enable <= (tx_code <= rffc_rate_848) && (rx_code <= rffc_rate_848); // [R2]
            suppress_tx_parity <= type_a_frame_settings[rffc_bit_no_tx_parity]; // [R3]
            raw_rx_with_parity <= type_a_frame_settings[rffc_bit_raw_rx] && (rx_code == rffc_rate_106); // [R4]
            transport_frame_enable <= type_a_frame_settings[rffc_bit_transport]; // [R6]
            transport_start_byte <= rffc_start_byte; // [R6]
            anticollision_frame <= type_a_frame_settings[rffc_bit_anticoll];
            pause_width <= next_pause; // [R8]
            extra_guard_time <= type_b_frame_settings[7:5]; // [R12]
            sof_low_half_etu <= next_sof_low; // [R13]
            sof_high_half_etu <= next_sof_high; // [R14]
            eof_low_half_etu <= next_eof; // [R15]
            skip_card_sof <= type_b_f_response_settings[rffc_bit_skip_sof]; // [R17]
            skip_card_eof <= type_b_f_response_settings[rffc_bit_skip_eof]; // [R18]
            preamble_bits <= rffc_preamble_base + 7'(rffc_preamble_step * type_b_f_response_settings[1:0]); // [R19]
            if (type_b_f_response_settings[7:6] == 2'b01) // [R20]
                min_tr1_fs <= (rx_code == rffc_rate_106) ? rffc_tr1_short_106 : rffc_tr1_short_fast;
            else
                min_tr1_fs <= rffc_tr1_default;
        end
    end

    property p_pready_timing;
        @(posedge pclk) disable iff (!presetn)
        (psel && !penable && clk_en) |=> pready;
    endproperty
    a_pready_timing: assert property (p_pready_timing) else $error("pready late");

    property p_hold_mid_frame;
        @(posedge pclk) disable iff (!presetn)
        !idle_s2 |=> $stable(pause_width) && $stable(tx_speed_code) && $stable(preamble_bits);
    endproperty
    a_hold_mid_frame: assert property (p_hold_mid_frame) else $error("settings changed mid frame"); // [R22]

    property p_bad_rate_off;
        @(posedge pclk) disable iff (!presetn)
        (clk_en && idle_s2 && (tx_code > rffc_rate_848)) |=> !tx_enable && !rx_enable;
    endproperty
    a_bad_rate_off: assert property (p_bad_rate_off) else $error("bad rate left enabled"); // [R2]

    property p_raw_only_106;
        @(posedge pclk) disable iff (!presetn)
        raw_rx_with_parity |-> rx_speed_code == rffc_rate_106;
    endproperty
    a_raw_only_106: assert property (p_raw_only_106) else $error("raw receive at high rate"); // [R4]

    property p_mid_spec;
        @(posedge pclk) disable iff (!presetn)
        (clk_en && idle_s2 && type_b_frame_settings[rffc_bit_mid_spec]) |=> sof_high_half_etu == 5'h05;
    endproperty
    a_mid_spec: assert property (p_mid_spec) else $error("mid sof high wrong"); // [R16]

    property p_pause_106;
        @(posedge pclk) disable iff (!presetn)
        (clk_en && idle_s2 && !stream_mode && tx_code == 4'h0 && pw_code == 4'h7) |=> pause_width == 8'h2a;
    endproperty
    a_pause_106: assert property (p_pause_106) else $error("pause width not 42"); // [R9]

    property p_stream_pause;
        @(posedge pclk) disable iff (!presetn)
        (clk_en && idle_s2 && stream_mode && pw_code == 4'h0) |=> pause_width == 8'h80;
    endproperty
    a_stream_pause: assert property (p_stream_pause) else $error("stream pause not 128"); // [R10]

    property p_preamble;
        @(posedge pclk) disable iff (!presetn)
        (clk_en && idle_s2 && type_b_f_response_settings[1:0] == 2'b11) |=> preamble_bits == 7'h60;
    endproperty
    a_preamble: assert property (p_preamble) else $error("preamble not 96"); // [R19]

    property p_rx_rate_off;
        @(posedge pclk) disable iff (!presetn)
        (clk_en && idle_s2 && (rx_code > rffc_rate_848)) |=> !tx_enable && !rx_enable;
    endproperty
    a_rx_rate_off: assert property (p_rx_rate_off) else $error("bad receive rate left enabled"); // [R2]

    property p_good_rate_on;
        @(posedge pclk) disable iff (!presetn)
        (clk_en && idle_s2 && (tx_code <= rffc_rate_848) && (rx_code <= rffc_rate_848))
            |=> tx_enable && rx_enable;
    endproperty
    a_good_rate_on: assert property (p_good_rate_on) else $error("supported rate left disabled"); // [R1]

    property p_pready_pulse;
        @(posedge pclk) disable iff (!presetn)
        (pready && clk_en) |=> !pready;
    endproperty
    a_pready_pulse: assert property (p_pready_pulse) else $error("pready held too long");

    property p_sof_low_long;
        @(posedge pclk) disable iff (!presetn)
        (clk_en && idle_s2 && !type_b_frame_settings[rffc_bit_mid_spec]
            && type_b_frame_settings[rffc_bit_sof_low]) |=> sof_low_half_etu == 5'h16;
    endproperty
    a_sof_low_long: assert property (p_sof_low_long) else $error("sof low not 11 etu"); // [R13]

    property p_sof_high_long;
        @(posedge pclk) disable iff (!presetn)
        (clk_en && idle_s2 && !type_b_frame_settings[rffc_bit_mid_spec]
            && type_b_frame_settings[rffc_bit_sof_high]) |=> sof_high_half_etu == 5'h06;
    endproperty
    a_sof_high_long: assert property (p_sof_high_long) else $error("sof high not 3 etu"); // [R14]

    property p_eof_long;
        @(posedge pclk) disable iff (!presetn)
        (clk_en && idle_s2 && !type_b_frame_settings[rffc_bit_mid_spec]
            && type_b_frame_settings[rffc_bit_eof_low]) |=> eof_low_half_etu == 5'h16;
    endproperty
    a_eof_long: assert property (p_eof_long) else $error("eof low not 11 etu"); // [R15]

    property p_tr1_short;
        @(posedge pclk) disable iff (!presetn)
        (clk_en && idle_s2 && (type_b_f_response_settings[7:6] == 2'b01) && (rx_code == rffc_rate_106))
            |=> min_tr1_fs == 7'h40;
    endproperty
    a_tr1_short: assert property (p_tr1_short) else $error("minimum tr1 not 64"); // [R20]

    property p_pause_wrap;
        @(posedge pclk) disable iff (!presetn)
        (clk_en && idle_s2 && !stream_mode && (tx_code == 4'h0) && (pw_code == 4'he)) |=> pause_width == 8'h21;
    endproperty
    a_pause_wrap: assert property (p_pause_wrap) else $error("pause width not 33"); // [R9]

    property p_guard;
        @(posedge pclk) disable iff (!presetn)
        (clk_en && idle_s2) |=> extra_guard_time == $past(type_b_frame_settings[7:5]);
    endproperty
    a_guard: assert property (p_guard) else $error("guard time not loaded"); // [R12]
endmodule

// file: src/rffc_pkg.sv
// Package with register map, field positions, reset values and timing constants of the frame configuration block.
package rffc_pkg;
    localparam logic [11:0] rffc_off_speed = 12'h010;
    localparam logic [11:0] rffc_off_type_a = 12'h014;
    localparam logic [11:0] rffc_off_type_b = 12'h018;
    localparam logic [11:0] rffc_off_resp = 12'h01c;
    localparam logic [11:0] rffc_off_mode = 12'h020;
    localparam logic [11:0] rffc_off_status = 12'h024;
    localparam logic [7:0] rffc_type_a_reset = 8'h00;
    localparam logic [7:0] rffc_type_b_reset = 8'h00;
    localparam logic [7:0] rffc_resp_reset = 8'h00;
    localparam logic [7:0] rffc_speed_reset = 8'h00;
    localparam logic [7:0] rffc_mode_reset = 8'h01;
    localparam int rffc_bit_no_tx_parity = 7;
    localparam int rffc_bit_raw_rx = 6;
    localparam int rffc_bit_transport = 5;
    localparam int rffc_bit_anticoll = 0;
    localparam int rffc_bit_sof_low = 4;
    localparam int rffc_bit_sof_high = 3;
    localparam int rffc_bit_eof_low = 2;
    localparam int rffc_bit_mid_spec = 1;
    localparam int rffc_bit_skip_sof = 5;
    localparam int rffc_bit_skip_eof = 4;
    localparam logic [3:0] rffc_rate_106 = 4'h0;
    localparam logic [3:0] rffc_rate_848 = 4'h3;
    localparam logic [3:0] rffc_om_subcarrier = 4'he;
    localparam logic [7:0] rffc_start_byte = 8'hf0;
    localparam logic [7:0] rffc_pw_base_106 = 8'h23;
    localparam logic [7:0] rffc_pw_base_212 = 8'h12;
    localparam logic [7:0] rffc_pw_base_424 = 8'h09;
    localparam logic [7:0] rffc_pw_base_848 = 8'h05;
    localparam logic [7:0] rffc_pw_stream_0 = 8'h80;
    localparam logic [7:0] rffc_pw_stream_f = 8'h78;
    localparam logic [7:0] rffc_pw_stream_e = 8'h70;
    localparam logic [3:0] rffc_sof_low_short = 4'ha;
    localparam logic [3:0] rffc_sof_low_long = 4'hb;
    localparam logic [3:0] rffc_sof_high_short = 4'h2;
    localparam logic [3:0] rffc_sof_high_long = 4'h3;
    localparam logic [3:0] rffc_eof_short = 4'ha;
    localparam logic [3:0] rffc_eof_long = 4'hb;
    localparam logic [4:0] rffc_mid_sof_low_half = 5'h15;
    localparam logic [4:0] rffc_mid_sof_high_half = 5'h05;
    localparam logic [4:0] rffc_mid_eof_half = 5'h15;
    localparam logic [6:0] rffc_preamble_base = 7'h30;
    localparam logic [6:0] rffc_preamble_step = 7'h10;
    localparam logic [6:0] rffc_tr1_default = 7'h50;
    localparam logic [6:0] rffc_tr1_short_106 = 7'h40;
    localparam logic [6:0] rffc_tr1_short_fast = 7'h20;
    localparam logic [31:0] rffc_status_reset = 32'h0000_0000;
endpackage

// file: testbench/rf_frame_format_config_tb.sv
// Self-checking bench for the frame configuration block.
`timescale 1ns/10ps
module rf_frame_format_config_tb;
    import rffc_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, frame_go, frame_idle, tx_enable, rx_enable;
    logic suppress_tx_parity, raw_rx_with_parity, transport_frame_enable, anticollision_frame;
    logic skip_card_sof, skip_card_eof, clk_en;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0] frame_len, transport_start_byte, pause_width;
    logic [3:0] tx_speed_code, rx_speed_code;
    logic [2:0] extra_guard_time;
    logic [4:0] sof_low_half_etu, sof_high_half_etu, eof_low_half_etu;
    logic [6:0] preamble_bits, min_tr1_fs;
    logic [1:0] stream_tx_period, ap_stp;
    logic [7:0] wr [5];
    logic [7:0] ap [5];
    int err_total, comparisons;
    rffc_frame_config i_rffc_frame_config
    (
        .pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .frame_idle, .stream_tx_period, .tx_enable, .rx_enable, .tx_speed_code, .rx_speed_code,
        .suppress_tx_parity, .raw_rx_with_parity, .transport_frame_enable, .transport_start_byte,
        .anticollision_frame, .pause_width, .extra_guard_time, .sof_low_half_etu, .sof_high_half_etu,
        .eof_low_half_etu, .skip_card_sof, .skip_card_eof, .preamble_bits, .min_tr1_fs
    );
    rffc_coder_model i_rffc_coder_model
    (
        .pclk, .presetn, .frame_go, .frame_len, .frame_idle
    );
    initial
    begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    task automatic complete_run();
        $display("Comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp)
        begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    // The request is held until pready is sampled high, then released with one idle edge after it.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q,
                       output logic e);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n == 20)
        begin
            err_total++;
            complete_run();
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rd_reg(input logic [11:0] a, input logic [31:0] exp, input logic experr);
        logic e;
        apb(1'b0, a, 32'h0, rd, e);
        chk("prdata", exp, rd);
        chk("pslverr", {31'h0, experr}, {31'h0, e});
    endtask
    task automatic wr_reg(input logic [11:0] a, input logic [7:0] v, input logic experr);
        logic [31:0] d;
        logic e;
        d = $urandom();
        d[7:0] = v;
        apb(1'b1, a, d, rd, e);
        chk("pslverr", {31'h0, experr}, {31'h0, e});
    endtask
    function automatic logic [11:0] addr(input int i);
        return rffc_off_speed + 12'(4 * i);
    endfunction
    function automatic logic rate_ok();
        return (ap[0][7:4] <= 4'h3) && (ap[0][3:0] <= 4'h3);
    endfunction
    function automatic logic [7:0] exp_pw();
        logic [7:0] base [4];
        logic [3:0] c;
        base = '{8'h23, 8'h12, 8'h09, 8'h05};
        c = ap[1][4:1];
        if (ap[4][3:0] == 4'he && ap_stp == 2'b00)
            return (c == 4'hf) ? 8'h78 : (c == 4'he) ? 8'h70 : 8'h80;
        return base[ap[0][5:4]] + {{4{c[3]}}, c};
    endfunction
    task automatic check_all();
        logic mid;
        mid = ap[2][1];
        chk("tx_enable", 32'(rate_ok()), 32'(tx_enable));
        chk("rx_enable", 32'(rate_ok()), 32'(rx_enable));
        chk("tx_speed_code", 32'(ap[0][7:4]), 32'(tx_speed_code));
        chk("rx_speed_code", 32'(ap[0][3:0]), 32'(rx_speed_code));
        chk("suppress_tx_parity", 32'(ap[1][7]), 32'(suppress_tx_parity));
        chk("raw_rx_with_parity", 32'(ap[1][6] & (ap[0][3:0] == 4'h0)), 32'(raw_rx_with_parity));
        chk("transport_frame_enable", 32'(ap[1][5]), 32'(transport_frame_enable));
        chk("transport_start_byte", 32'hf0, 32'(transport_start_byte));
        chk("anticollision_frame", 32'(ap[1][0]), 32'(anticollision_frame));
        chk("pause_width", 32'(exp_pw()), 32'(pause_width));
        chk("extra_guard_time", 32'(ap[2][7:5]), 32'(extra_guard_time));
        chk("sof_low", mid ? 32'h15 : (ap[2][4] ? 32'h16 : 32'h14), 32'(sof_low_half_etu));
        chk("sof_high", mid ? 32'h05 : (ap[2][3] ? 32'h06 : 32'h04), 32'(sof_high_half_etu));
        chk("eof_low", mid ? 32'h15 : (ap[2][2] ? 32'h16 : 32'h14), 32'(eof_low_half_etu));
        chk("skip_card_sof", 32'(ap[3][5]), 32'(skip_card_sof));
        chk("skip_card_eof", 32'(ap[3][4]), 32'(skip_card_eof));
        chk("preamble_bits", 32'h30 + 32'h10 * 32'(ap[3][1:0]), 32'(preamble_bits));
        chk("min_tr1_fs", ap[3][6] ? ((ap[0][3:0] == 4'h0) ? 32'h40 : 32'h20) : 32'h50, 32'(min_tr1_fs));
    endtask
    initial
    begin
        logic [3:0] corner [6];
        int n;
        corner = '{4'h0, 4'hf, 4'he, 4'h7, 4'hf, 4'he};
        {presetn, psel, penable, pwrite, frame_go, paddr, pwdata, frame_len, stream_tx_period} = '0;
        clk_en = 1'b1;
        wr = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01};
        ap = wr;
        ap_stp = 2'b00;
        err_total = 0;
        comparisons = 0;
        void'($urandom(32'hf85b3c14));
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        repeat (5) @(posedge pclk);
        check_all();
        for (int i = 0; i < 5; i++)
            rd_reg(addr(i), {24'h0, wr[i]}, 1'b0);
        wr_reg(12'h028, 8'h5a, 1'b1);
        rd_reg(12'h028, 32'h0, 1'b1);
        for (int k = 0; k < 40; k++)
        begin
            frame_go <= 1'b1;
            frame_len <= 8'd60;
            @(posedge pclk);
            frame_go <= 1'b0;
            repeat (3) @(posedge pclk);
            // Only reader modes are chosen, never bit rate detection, so every option may be set.
            wr[4] = ((k >= 6 && k % 2 == 1) || k < 3) ? 8'h0e : 8'h01;
            stream_tx_period <= (k < 6) ? 2'b00 : 2'($urandom());
            // Every eighth pass uses the whole byte, so unsupported speed codes reach the decoder.
            wr[0] = 8'($urandom()) & ((k % 8 == 7) ? 8'hff : 8'h33);
            wr[1] = 8'($urandom());
            wr[2] = 8'($urandom()) & 8'hfe;
            wr[3] = 8'($urandom()) & 8'h73;
            if (k < 6)
            begin
                wr[1][4:1] = corner[k];
                wr[0][5:4] = 2'b00;
            end
            for (int i = 0; i < 5; i++)
                wr_reg(addr(i), wr[i], 1'b0);
            for (int i = 0; i < 5; i++)
                rd_reg(addr(i), {24'h0, wr[i]}, 1'b0);
            check_all();
            if (k == 3)
                clk_en <= 1'b0;
            n = 0;
            while (frame_idle !== 1'b1 && n < 100)
            begin
                @(posedge pclk);
                n++;
            end
            if (n == 100)
            begin
                err_total++;
                complete_run();
            end
            repeat (4) @(posedge pclk);
            // With the clock enable low the idle synchroniser is frozen, so the old settings must stand.
            if (k == 3)
            begin
                check_all();
                clk_en <= 1'b1;
                repeat (4) @(posedge pclk);
            end
            ap = wr;
            ap_stp = stream_tx_period;
            check_all();
            rd_reg(rffc_off_status, rate_ok() ? 32'h3 : 32'h0, 1'b0);
        end
        complete_run();
    end
endmodule

// file: testbench/rffc_coder_model.sv
// Behavioural coder that frames traffic and reports when it rests between frames.
`timescale 1ns/10ps
module rffc_coder_model
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic frame_go,
    input wire logic [7:0] frame_len,
    output logic frame_idle
);
    logic [7:0] left;
    // A frame in flight keeps the coder busy, which is when settings must not move.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            left <= 8'h00;
        else if (frame_go)
            left <= frame_len;
        else if (left != 8'h00)
            left <= left - 8'h01;
    end
    assign frame_idle = (left == 8'h00);
endmodule
